/* hw/frtc_ramp.sv */
/*
 * Output frequency ramp controller with two time sets, start hold and
 * S-pattern A timing. Assumes all inputs synchronous to clk and settings
 * held steady by the surrounding parameter store.
 */
`timescale 1ns/1ps
`include "frtc_cfg.svh"

// Functional notes
// - Accel time spans zero to reference frequency.
// - Decel time spans reference frequency to zero.
// - Time unit 0.1 s or 0.01 s.
// - Unit change rescales stored times, restart untouched.
// - Second set on input or above switchover.
// - Second decel sentinel uses second accel.
// - Switchover sentinel keeps primary times.
// - Switchover zero uses second set always.
// - Primary below switchover, second at/above.
// - Unreached switchover keeps primary times.
// - Second-set input overrides low frequency.
// - S-pattern A stretches time above base.
// - Times up to 0.03 s become 0.04 s.
// - Second-set input mappable by function code 3.
// - Starting frequency applied at start.
// - No start below starting frequency.
// - Hold time 0-10 s, sentinel disables.
// - Hold starting frequency before ramping.
// - Zero starting frequency holds 0.01 Hz.
// - Start removed in hold decelerates at once.
// - Reversal uses starting frequency, skips hold.
// - Low starting frequency runs at minimum frequency.
// - Reference frequency 1-400 Hz, default 60.
// - Pattern 1 selects S-pattern A.
module frtc_ramp #(
    parameter int     NUM_TERMINALS = 12,
    parameter int     SECOND_TERM   = 2,
    parameter longint CYC_PER_BASE  = `FRTC_CYC_PER_BASE
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // Run commands
    input  wire logic                       start,
    input  wire logic                       reverse,
    input  wire frtc_pkg::frtc_freq_t       freq_command,
    // Input terminals and their function codes
    input  wire logic [NUM_TERMINALS-1:0]   input_terminals,
    input  wire logic [NUM_TERMINALS*8-1:0] input_function_selectors,
    // Ramp time settings
    input  wire logic                       time_increment_select,
    input  wire logic [15:0]                accel_time,
    input  wire logic [15:0]                decel_time,
    input  wire logic [15:0]                second_accel_time,
    input  wire logic [15:0]                second_decel_time,
    // Frequency, start hold and pattern settings
    input  wire frtc_pkg::frtc_freq_t       ramp_reference_frequency,
    input  wire frtc_pkg::frtc_freq_t       ramp_switch_frequency,
    input  wire frtc_pkg::frtc_freq_t       starting_frequency,
    input  wire frtc_pkg::frtc_freq_t       minimum_frequency,
    input  wire frtc_pkg::frtc_freq_t       base_frequency,
    input  wire logic [15:0]                start_hold_time,
    input  wire logic [1:0]                 ramp_pattern_select,
    // Outputs to the power stage
    output frtc_pkg::frtc_freq_t            freq_out,
    output logic                            dir_out,
    output logic                            running,
    output logic                            second_set_active
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Time setting to ramp length in clock cycles, with the 0.04 s floor
    function automatic logic [39:0] time_cycles(input logic [15:0] raw,
                                                input logic        fine);
        logic [19:0] base;
        base = fine ? {4'h0, raw} : 20'({4'h0, raw} * `FRTC_TENTH_IN_BASE);
        if (base <= `FRTC_TMIN_LIMIT) begin
            base = `FRTC_TMIN_ACTUAL;
        end
        return 40'(base * CYC_PER_BASE);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Time set selection

    logic        sec_in;   // Second-set input after terminal mapping
    logic        sw_hit;   // Output at or above switchover frequency
    logic        sel2;     // Second time set in use
    logic [15:0] acc_raw;  // Active acceleration setting
    logic [15:0] dec_raw;  // Active deceleration setting

    // Gather every terminal coded for the second-set function
    always_comb begin
        sec_in = 1'b0;
        for (int i = 0; i < NUM_TERMINALS; i++) begin
            if (input_function_selectors[i*8 +: 8] == `FRTC_FUNC_SECOND) begin
                sec_in = sec_in | input_terminals[i];
            end
        end
    end

    // Re-decided each cycle so the slope changes mid-ramp
    always_comb begin
        sw_hit  = (ramp_switch_frequency != `FRTC_SENTINEL)
                  && (freq_out >= ramp_switch_frequency);
        sel2    = sec_in | sw_hit;
        acc_raw = sel2 ? second_accel_time : accel_time;
        if (!sel2) begin
            dec_raw = decel_time;
        end else if (second_decel_time == `FRTC_SENTINEL) begin
            dec_raw = second_accel_time;
        end else begin
            dec_raw = second_decel_time;
        end
    end

    assign second_set_active = sel2;

    ////////////////////////////////////////////////////////////////////////
    // Target frequency and slope

    frtc_pkg::frtc_freq_t cmd_eff;  // Command raised to minimum frequency
    frtc_pkg::frtc_freq_t launch_f; // Frequency applied at start
    frtc_pkg::frtc_freq_t tgt;      // Frequency the ramp heads for
    frtc_pkg::frtc_wide_t inc;      // Per-cycle accumulator addend
    frtc_pkg::frtc_wide_t thr;      // Accumulator threshold for one count
    frtc_pkg::frtc_wide_t tcyc;     // Active time in cycles
    frtc_pkg::frtc_wide_t fs;       // Set frequency, widened
    frtc_pkg::frtc_wide_t fb;       // Base frequency, widened
    logic                 can_go;   // Command high enough to start
    logic                 rev_req;  // Direction request differs

    frtc_pkg::frtc_state_e state_reg, state_next;
    frtc_pkg::frtc_freq_t  freq_reg, freq_next;
    frtc_pkg::frtc_wide_t  acc_reg, acc_next;
    logic                  dir_reg, dir_next;
    logic                  up_reg, up_next;
    logic [19:0]           hold_reg, hold_next;
    logic [39:0]           tick_reg, tick_next;

    // Command conditioning and start permission
    always_comb begin
        // Minimum frequency lifts the command, for start permission as well
        cmd_eff = (freq_command < minimum_frequency) ? minimum_frequency
                                                      : freq_command;
        can_go  = cmd_eff >= starting_frequency;
        launch_f = (starting_frequency == 16'h0000) ? `FRTC_HOLD_FLOOR
                                                   : starting_frequency;
        rev_req = reverse != dir_reg;
        if (!start || rev_req || state_reg == frtc_pkg::FRTC_IDLE) begin
            tgt = 16'h0000;
        end else begin
            tgt = cmd_eff;
        end
    end

    // Slope as addend over threshold
    always_comb begin
        fs   = 80'(cmd_eff);
        fb   = 80'(base_frequency);
        tcyc = 80'(time_cycles(up_next ? acc_raw : dec_raw, time_increment_select));
        if (ramp_pattern_select == `FRTC_PAT_S_A && fs >= fb) begin
            // Total time 4/9*T*(f/fb)^2 + 5/9*T to reach f
            inc = `FRTC_SA_DEN * fs * fb * fb;
            thr = tcyc * (`FRTC_SA_QUAD * fs * fs + `FRTC_SA_LIN * fb * fb);
        end else if (ramp_pattern_select == `FRTC_PAT_S_A) begin
            // Below base the time setting spans zero to base
            inc = fb;
            thr = tcyc;
        end else begin
            // Reference over time in both directions
            inc = 80'(ramp_reference_frequency);
            thr = tcyc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and ramp

    // Next-state logic
    always_comb begin
        state_next = state_reg;
        freq_next  = freq_reg;
        acc_next   = acc_reg;
        dir_next   = dir_reg;
        hold_next  = hold_reg;
        tick_next  = tick_reg;
        up_next    = freq_reg < tgt;
        unique case (state_reg)
            // Stopped: launch at starting frequency
            frtc_pkg::FRTC_IDLE: begin
                acc_next = '0;
                if (start && can_go) begin
                    freq_next = launch_f;
                    dir_next  = reverse;
                    tick_next = '0;
                    hold_next = 20'({4'h0, start_hold_time} * `FRTC_TENTH_IN_BASE);
                    if (start_hold_time != `FRTC_SENTINEL) begin
                        state_next = frtc_pkg::FRTC_HOLD;
                    end else begin
                        state_next = frtc_pkg::FRTC_RUN;
                    end
                end
            end
            // Hold the launch frequency for excitation
            frtc_pkg::FRTC_HOLD: begin
                if (!start) begin
                    state_next = frtc_pkg::FRTC_RUN;
                end else if (hold_reg == 20'h00000) begin
                    state_next = frtc_pkg::FRTC_RUN;
                end else if (tick_reg == 40'(CYC_PER_BASE - 1)) begin
                    tick_next = '0;
                    hold_next = hold_reg - 20'h00001;
                end else begin
                    tick_next = tick_reg + 40'h1;
                end
            end
            // Ramp toward target, one count at a time
            frtc_pkg::FRTC_RUN: begin
                if (freq_reg == tgt) begin
                    acc_next = '0;
                end else if (acc_reg + inc >= thr) begin
                    acc_next  = acc_reg + inc - thr;
                    freq_next = up_next ? freq_reg + 16'h0001 : freq_reg - 16'h0001;
                end else begin
                    acc_next = acc_reg + inc;
                end
                if (up_next != up_reg) begin
                    acc_next = '0;
                end
                if (freq_reg == 16'h0000 && start && rev_req) begin
                    // Reversal: relaunch without the hold
                    freq_next = launch_f;
                    dir_next  = reverse;
                end else if (freq_reg == 16'h0000 && !start) begin
                    state_next = frtc_pkg::FRTC_IDLE;
                end
            end
            default: begin
                state_next = frtc_pkg::FRTC_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= frtc_pkg::FRTC_IDLE;
            freq_reg  <= 16'h0000;
            acc_reg   <= '0;
            dir_reg   <= 1'b0;
            up_reg    <= 1'b0;
            hold_reg  <= 20'h00000;
            tick_reg  <= 40'h0;
        end else begin
            state_reg <= state_next;
            freq_reg  <= freq_next;
            acc_reg   <= acc_next;
            dir_reg   <= dir_next;
            up_reg    <= up_next;
            hold_reg  <= hold_next;
            tick_reg  <= tick_next;
        end
    end

    assign freq_out = freq_reg;
    assign dir_out  = dir_reg;
    assign running  = state_reg != frtc_pkg::FRTC_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    // Launch request from standstill
    sequence seq_launch;
        state_reg == frtc_pkg::FRTC_IDLE && start && can_go;
    endsequence

    // Launch lands on starting frequency, or 0.01 Hz when that is zero
    AST_LAUNCH_FREQ: assert property (@(posedge clk) disable iff (rst)
        seq_launch |=> freq_out == $past(launch_f) && running)
        else $error("launch frequency wrong");

    AST_NO_START: assert property (@(posedge clk) disable iff (rst)
        state_reg == frtc_pkg::FRTC_IDLE && !can_go |=> freq_out == 16'h0000)
        else $error("started below starting frequency");

    AST_HOLD_ENTRY: assert property (@(posedge clk) disable iff (rst)
        seq_launch ##0 start_hold_time == `FRTC_SENTINEL |=> state_reg == frtc_pkg::FRTC_RUN)
        else $error("hold entered though disabled");

    AST_HOLD_STEADY: assert property (@(posedge clk) disable iff (rst)
        state_reg == frtc_pkg::FRTC_HOLD ##1 state_reg == frtc_pkg::FRTC_HOLD
        |-> $stable(freq_out))
        else $error("frequency moved during hold");

    AST_HOLD_ABORT: assert property (@(posedge clk) disable iff (rst)
        state_reg == frtc_pkg::FRTC_HOLD && !start |=> state_reg == frtc_pkg::FRTC_RUN)
        else $error("hold not abandoned");

    AST_ZERO_FLOOR: assert property (@(posedge clk) disable iff (rst)
        state_reg == frtc_pkg::FRTC_HOLD |-> freq_out != 16'h0000)
        else $error("hold at zero frequency");

    AST_INPUT_SEL: assert property (@(posedge clk) disable iff (rst)
        sec_in |-> second_set_active)
        else $error("second-set input ignored");

    AST_SW_SENT: assert property (@(posedge clk) disable iff (rst)
        ramp_switch_frequency == `FRTC_SENTINEL && !sec_in |-> !second_set_active)
        else $error("automatic switch with sentinel");

    AST_SW_ZERO: assert property (@(posedge clk) disable iff (rst)
        ramp_switch_frequency == 16'h0000 |-> second_set_active)
        else $error("zero switchover not second set");

    AST_STEP: assert property (@(posedge clk) disable iff (rst)
        state_reg == frtc_pkg::FRTC_RUN && $past(state_reg) == frtc_pkg::FRTC_RUN
        && $past(freq_out) != 16'h0000
        |-> freq_out - $past(freq_out) <= 16'h0001 || $past(freq_out) - freq_out <= 16'h0001)
        else $error("ramp step over one count");

    AST_MIN_TIME: assert property (@(posedge clk) disable iff (rst)
        accel_time <= 16'h0003 && time_increment_select
        |-> time_cycles(accel_time, 1'b1) == 40'(`FRTC_TMIN_ACTUAL * CYC_PER_BASE))
        else $error("short ramp time not floored");

    AST_REV_NOHOLD: assert property (@(posedge clk) disable iff (rst)
        state_reg == frtc_pkg::FRTC_RUN && freq_out == 16'h0000 && start && rev_req
        |=> state_reg == frtc_pkg::FRTC_RUN && freq_out == $past(launch_f))
        else $error("reversal relaunch wrong");

endmodule

/* inc/frtc_cfg.svh */
/*
 * Constants of the frequency ramp controller: units, sentinels, timing.
 * Assumes frequencies in 0.01 Hz counts and a 200 MHz control clock.
 */
`ifndef FRTC_CFG_SVH
`define FRTC_CFG_SVH

// Clock rate in Hz and the 10 ms time base in cycles
`define FRTC_CLK_HZ         200000000
`define FRTC_BASE_MS        10
`define FRTC_CYC_PER_BASE   (`FRTC_CLK_HZ / 1000 * `FRTC_BASE_MS)
// Setting value that switches a function off or ties decel to accel
`define FRTC_SENTINEL       16'h270F
// Ramp times of 0.03 s or less run as 0.04 s (10 ms units)
`define FRTC_TMIN_LIMIT     20'h00003
`define FRTC_TMIN_ACTUAL    20'h00004
// One 0.1 s step in 10 ms units
`define FRTC_TENTH_IN_BASE  20'h0000A
// Start hold frequency when the starting frequency is zero (0.01 Hz)
`define FRTC_HOLD_FLOOR     16'h0001
// Input function code that routes a terminal to the second-set input
`define FRTC_FUNC_SECOND    8'h03
// Ramp pattern codes
`define FRTC_PAT_LINEAR     2'h0
`define FRTC_PAT_S_A        2'h1
// S-pattern A weights (4/9 and 5/9)
`define FRTC_SA_QUAD        80'h4
`define FRTC_SA_LIN         80'h5
`define FRTC_SA_DEN         80'h9

`endif

/* inc/frtc_pkg.sv */
/*
 * Types of the frequency ramp controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package frtc_pkg;
    // Sequencer states
    typedef enum logic [1:0] {
        FRTC_IDLE,
        FRTC_HOLD,
        FRTC_RUN
    } frtc_state_e;
    // Frequency in 0.01 Hz counts
    typedef logic [15:0] frtc_freq_t;
    // Wide ramp arithmetic
    typedef logic [79:0] frtc_wide_t;
endpackage

/* sim/frtc_stage_model.sv */
/*
 * Power stage model that takes the ramp controller's drive commands.
 * Assumes the controller's clock and reset; it only watches and counts faults.
 */
`timescale 1ns/1ps

module frtc_stage_model (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Drive commands
    input  wire frtc_pkg::frtc_freq_t freq_out,
    input  wire logic                 dir_out,
    input  wire logic                 running,
    // Commands the stage could not obey
    output int                        faults
);
    frtc_pkg::frtc_freq_t freq_reg; // Last frequency applied
    logic                 dir_reg;  // Last direction applied

    ////////////////////////////////////////////////////////////////////////
    // Direction may only turn round at standstill; no frequency while not running
    always @(posedge clk) begin
        if (rst) begin
            freq_reg <= 16'h0000;
            dir_reg  <= 1'b0;
            faults   <= 0;
        end else begin
            freq_reg <= freq_out;
            dir_reg  <= dir_out;
            if (dir_out !== dir_reg && freq_reg !== 16'h0000) begin
                faults <= faults + 1;
            end
            if (!running && freq_out !== 16'h0000) begin
                faults <= faults + 1;
            end
        end
    end
endmodule

/* sim/frtc_ramp_tb.sv */
/*
 * Self-checking bench of the ramp controller with a power stage model.
 * Assumes the 10 ms base shrunk to 20 cycles, so one second is 2000 cycles.
 */
`timescale 1ns/1ps

module frtc_ramp_tb;
    localparam int CPB = 20;        // Cycles per 10 ms tick in this run
    localparam int SEC = CPB * 100; // Cycles per scaled second
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 start = 1'b0;
    logic                 reverse = 1'b0;
    frtc_pkg::frtc_freq_t cmd = 16'h0000;
    logic [11:0]          term = 12'h000;
    logic [95:0]          sel = {72'h0, 8'h03, 16'h0000}; // Second set on its own terminal
    logic                 unit = 1'b0;
    logic [15:0]          acc = 16'h000A, dec = 16'h000A, acc2 = 16'h0005, dec2 = 16'h270F;
    frtc_pkg::frtc_freq_t rfq = 16'h03E8, sw = 16'h270F, sf = 16'h0032;
    frtc_pkg::frtc_freq_t minf = 16'h0000, base = 16'h01F4;
    logic [15:0]          hold = 16'h270F;
    logic [1:0]           pat = 2'h0;
    frtc_pkg::frtc_freq_t freq_out;
    logic                 dir_out, running, second_set_active;
    int                   faults, n, n_errors = 0, num_checks = 0, cycles = 0;

    always #2.5 clk = ~clk;

    frtc_ramp #(.CYC_PER_BASE(CPB)) frtc_ramp_inst (
        .clk(clk), .rst(rst), .start(start), .reverse(reverse), .freq_command(cmd),
        .input_terminals(term), .input_function_selectors(sel),
        .time_increment_select(unit), .accel_time(acc), .decel_time(dec),
        .second_accel_time(acc2), .second_decel_time(dec2),
        .ramp_reference_frequency(rfq), .ramp_switch_frequency(sw),
        .starting_frequency(sf), .minimum_frequency(minf), .base_frequency(base),
        .start_hold_time(hold), .ramp_pattern_select(pat), .freq_out(freq_out),
        .dir_out(dir_out), .running(running), .second_set_active(second_set_active));

    frtc_stage_model frtc_stage_model_inst (
        .clk(clk), .rst(rst), .freq_out(freq_out), .dir_out(dir_out),
        .running(running), .faults(faults));

    ////////////////////////////////////////////////////////////////////////
    // Verdict and comparisons
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Exact value compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    // Ramp duration compare, small slack for step rounding
    task automatic chk_time(input int got, input int exp, input string what);
        int tol;
        tol = exp / 32 + 4;
        num_checks++;
        if (got < exp - tol || got > exp + tol) begin
            n_errors++;
            $display("Error %0t: %s took %0d cycles expected %0d", $time, what, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Drive helpers
    task automatic wait_freq(input logic [15:0] f, input int lim, output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (freq_out !== f && k < lim);
    endtask

    // Start with a command and look at the launch frequency
    task automatic launch(input logic [15:0] c, input logic [15:0] f0);
        @(posedge clk);
        cmd   <= c;
        start <= 1'b1;
        repeat (2) @(posedge clk);
        chk(freq_out, f0, "launch frequency");
        chk(running, f0 != 16'h0000, "running at launch");
    endtask

    // Remove start, ramp down, expect idle
    task automatic stop_all(input int lim, output int k);
        @(posedge clk);
        start <= 1'b0;
        wait_freq(16'h0000, lim, k);
        repeat (2) @(posedge clk);
        chk(running, 1'b0, "idle after stop");
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            $display("Error %0t: run did not finish", $time);
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({freq_out, dir_out, running}, 18'h00000, "reset outputs");
        chk(second_set_active, 1'b0, "primary after reset");
        $display("test reset done");
        // Command below starting frequency is refused
        launch(16'h0031, 16'h0000);
        repeat (50) @(posedge clk);
        chk(running, 1'b0, "refused start");
        start <= 1'b0;
        $display("test refuse done");
        // Linear ramp 0.5 Hz to 5.5 Hz at 10 Hz per second, down at the same
        launch(16'h0226, 16'h0032);
        wait_freq(16'h0226, 3000, n);
        chk_time(n, SEC / 2, "accel");
        stop_all(3000, n);
        chk_time(n, SEC * 550 / 1000, "decel");
        $display("test linear done");
        // Fine unit, 200 counts mean 2 s
        @(posedge clk);
        unit <= 1'b1;
        acc  <= 16'h00C8;
        launch(16'h0226, 16'h0032);
        wait_freq(16'h0226, 3000, n);
        chk_time(n, SEC, "fine accel");
        stop_all(3000, n);
        acc  <= 16'h0003; // Short fine time held one cycle, no ramp run; AST_MIN_TIME checks the 0.04 s floor
        @(posedge clk);
        unit <= 1'b0;
        acc  <= 16'h000A;
        $display("test unit done");
        // Second set through a remapped terminal, unmapped terminal ignored
        term[7] <= 1'b1;
        repeat (2) @(posedge clk);
        chk(second_set_active, 1'b0, "unmapped terminal");
        sel[47:40] <= 8'h03;
        term[5]    <= 1'b1;
        repeat (2) @(posedge clk);
        chk(second_set_active, 1'b1, "mapped terminal");
        launch(16'h0226, 16'h0032);
        wait_freq(16'h0226, 3000, n);
        chk_time(n, SEC / 4, "second accel");
        stop_all(3000, n);
        chk_time(n, SEC * 550 / 2000, "second decel tied to accel");
        term <= 12'h000;
        $display("test second set done");
        // Switchover at 3 Hz changes slope mid-ramp
        sw <= 16'h012C;
        launch(16'h0226, 16'h0032);
        wait_freq(16'h012C, 3000, n);
        chk_time(n, SEC / 4, "below switchover");
        wait_freq(16'h0226, 3000, n);
        chk_time(n, SEC / 8, "above switchover");
        chk(second_set_active, 1'b1, "second above switchover");
        stop_all(3000, n);
        sw <= 16'h0000;
        repeat (2) @(posedge clk);
        chk(second_set_active, 1'b1, "switchover zero");
        sw <= 16'h0258;
        launch(16'h0226, 16'h0032);
        wait_freq(16'h0226, 3000, n);
        chk(second_set_active, 1'b0, "switchover unreached");
        stop_all(3000, n);
        sw <= 16'h270F;
        $display("test switchover done");
        // Start hold at zero starting frequency, aborted then completed
        sf   <= 16'h0000;
        hold <= 16'h0002;
        launch(16'h0226, 16'h0001);
        repeat (300) @(posedge clk);
        chk(freq_out, 16'h0001, "held");
        stop_all(30, n);
        chk(n < 30, 1'b1, "hold abandoned");
        launch(16'h0226, 16'h0001);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (freq_out === 16'h0001 && n < 1000);
        chk_time(n, CPB * 20, "hold time");
        $display("test hold done");
        // Reversal ramps to zero, relaunches without hold
        wait_freq(16'h0226, 3000, n);
        reverse <= 1'b1;
        sf      <= 16'h0032;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dir_out !== 1'b1 && n < 3000);
        chk(freq_out, 16'h0032, "relaunch frequency");
        chk(dir_out, 1'b1, "reversed direction");
        wait_freq(16'h003C, 100, n);
        chk(n < 100, 1'b1, "no hold on reversal");
        stop_all(3000, n);
        reverse <= 1'b0;
        hold    <= 16'h270F;
        $display("test reversal done");
        // Minimum frequency above starting frequency runs with no command
        minf <= 16'h00C8;
        launch(16'h0000, 16'h0032);
        wait_freq(16'h00C8, 1000, n);
        chk_time(n, SEC * 150 / 1000, "run to minimum");
        stop_all(3000, n);
        minf <= 16'h0000;
        $display("test minimum done");
        // S-pattern A to twice base frequency
        pat <= 2'h1;
        launch(16'h03E8, 16'h0032);
        wait_freq(16'h03E8, 6000, n);
        chk_time(n, 950 * 21 * SEC / 9000, "pattern A accel");
        stop_all(6000, n);
        chk_time(n, 21 * SEC / 9, "pattern A decel");
        $display("test pattern done");
        chk(faults, 0, "stage faults");
        close_out();
    end
endmodule
